// [design/frc_field_osc_regulator.sv]
// Field detector, oscillator divider and regulator control with APB
// Overview of operation
// (RULE1) NFC event interrupt on rising edge of ORed field detector outputs.
// (RULE2) Target and collision thresholds come from separate register fields.
// (RULE3) Target detector enabled only while its operation control bit is set.
// (RULE4) Target detector interrupts on field appearing and on field vanishing.
// (RULE5) Live target detector output readable as field-present status bit.
// (RULE6) Collision avoidance sequence with its detector on precedes each send.
// (RULE7) Field during collision avoidance suppresses send, raises collision irq.
// (RULE8) Target detector held off throughout collision avoidance.
// (RULE9) Oscillator-ready interrupt once amplitude exceeds 750 mVpp.
// (RULE10) Core tick always 13.56 MHz; halved when 27.12 MHz crystal chosen.
// (RULE11) Host clock pin selectable among 13.56, 6.78 and 3.39 MHz; the divider gives 6.78, 3.39 and 1.695 MHz.
// (RULE12) Level 2.4 V to 3.4 V in 100 mV steps, same for both regulators.
// (RULE13) Regulators on when ready bit set or ready pin high.
// (RULE14) Read-only display register shows actual level while operating.
// (RULE15) Display register reads 00 in power-down.
// (RULE16) Level starts at 3.4 V maximum after power-up.
// (RULE17) Adjust command sets level 250 mV below logic supply.
// (RULE18) Manual bit 0 selects automatic level, 1 takes four-bit code.
// (RULE19) Any interrupt sets its source bit and drives interrupt pin high.
// (RULE20) Manual code maps linearly from 2.4 V, saturating at 3.4 V.
// (RULE21) Comparator outputs synchronised, then turned into one-cycle pulses.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module frc_field_osc_regulator
  import frc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire frc_apb_req_type apbReq,
  output frc_apb_rsp_type apbRsp,
  input wire logic tgtCmpIn,
  input wire logic caCmpIn,
  input wire logic oscAmpOkIn,
  input wire logic readyModeIn,
  input wire logic [5:0] vddLevelIn,
  output logic tgtEnableOut,
  output logic caEnableOut,
  output logic [3:0] tgtThresholdOut,
  output logic [3:0] caThresholdOut,
  output logic txStartOut,
  output logic coreTickOut,
  output logic mcuClkOut,
  output logic regEnableOut,
  output logic [3:0] supplyLevelOut,
  output logic irq_line_out
);

  typedef struct packed {
    // Software settings
    logic readyEn;
    logic nfcTgt;
    logic oscHalve;
    logic [1:0] mcuSel;
    logic [3:0] tgtThr;
    logic [3:0] caThr;
    logic manualSel;
    logic [3:0] supply_level_code;
    logic [3:0] autoLevel;
    // Synchronisers and edge history
    logic tgtS1;
    logic tgtS2;
    logic caS1;
    logic caS2;
    logic oscS1;
    logic oscS2;
    logic comboPrev;
    logic tgtPrev;
    logic oscPrev;
    // Interrupt sources and clock dividers
    logic [IRQ_W-1:0] irq;
    logic halfPhase;
    logic coreTick;
    logic [1:0] mcuCnt;
    logic mcuClk;
    // Sequencer
    frc_seq_type seq;
    logic [SEQ_CNT_W-1:0] seqCnt;
    logic collide;
    logic txStart;
    // Bus answer
    logic [31:0] prdata;
    logic pslverr;
  } frc_state_type;

  frc_state_type q;
  frc_state_type d;

  // Clamp a level code to the top of the range
  function automatic logic [3:0] clampLevel(input logic [3:0] code);
    clampLevel = (code > LEVEL_MAX) ? LEVEL_MAX : code;
  endfunction

  // Vdd minus margin, in 100 mV steps, clamped
  function automatic logic [3:0] autoTarget(input logic [5:0] vdd);
    logic [5:0] diff;
    diff = (vdd > VDD_MARGIN) ? vdd - VDD_MARGIN : 6'h00;
    autoTarget = clampLevel((diff[5:1] > 5'h0F) ? 4'hF : diff[4:1]);
  endfunction

  // Register address is one of the mapped words
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      ADDR_OP_CTRL, ADDR_CONFIG2, ADDR_THRESH, ADDR_REG_DEF,
      ADDR_REG_DISP, ADDR_STATUS, ADDR_IRQ, ADDR_COMMAND: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Bus decode
  logic setupPhase;
  logic accessPhase;
  logic wrStrobe;
  logic rdIrqStrobe;

  // Detector gating and events
  logic caActive;
  logic tgtLive;
  logic caLive;
  logic comboDet;
  logic nfcEvent;
  logic tgtFall;
  logic oscRise;
  logic collEvent;

  // Regulator and interrupt set terms
  logic regOn;
  logic [3:0] levelNow;
  logic [3:0] dispValue;
  logic [IRQ_W-1:0] irqSet;

  // Divider and read data
  logic [1:0] halfTicks;
  logic [31:0] rdWord;

  // Bus phases and strobes
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessPhase = apbReq.psel & apbReq.penable;
  assign wrStrobe = accessPhase & apbReq.pwrite;
  assign rdIrqStrobe = accessPhase & ~apbReq.pwrite &
    (apbReq.paddr == ADDR_IRQ);

  // Detector gating and event decode
  // Gating the target detector off also reads as the field going away
  assign caActive = (q.seq == SEQ_CA);
  assign tgtLive = q.tgtS2 & q.nfcTgt & ~caActive; // RULE3 RULE8
  assign caLive = q.caS2 & caActive;
  assign comboDet = tgtLive | caLive; // RULE1
  assign nfcEvent = comboDet & ~q.comboPrev; // RULE1 RULE21
  assign tgtFall = ~tgtLive & q.tgtPrev; // RULE4
  assign oscRise = q.oscS2 & ~q.oscPrev; // RULE9 RULE21
  assign collEvent = caLive & ~q.collide; // RULE7

  // Regulator level and display
  assign regOn = q.readyEn | readyModeIn; // RULE13
  assign levelNow = q.manualSel ? clampLevel(q.supply_level_code) // RULE18
                                : q.autoLevel; // RULE20
  assign dispValue = regOn ? levelNow : DISP_OFF; // RULE14 RULE15

  // Interrupt sources
  always_comb begin
    irqSet = '0;
    irqSet[IRQ_NFC_BIT] = nfcEvent | tgtFall; // RULE1 RULE4
    irqSet[IRQ_COLL_BIT] = collEvent; // RULE7
    irqSet[IRQ_OSC_BIT] = oscRise; // RULE9
  end

  // Host clock half period in core ticks, less one
  // Settings 2 and 3 both give the slowest host clock
  always_comb begin
    case (q.mcuSel)
      MCU_FULL: halfTicks = 2'd0;
      MCU_HALF: halfTicks = 2'd1;
      default: halfTicks = 2'd3;
    endcase
  end

  // Read data multiplexer
  always_comb begin
    rdWord = ZERO_WORD;
    case (apbReq.paddr)
      ADDR_OP_CTRL: begin
        rdWord[OP_READY_BIT] = q.readyEn;
        rdWord[OP_NFC_TGT_BIT] = q.nfcTgt;
      end
      ADDR_CONFIG2: begin
        rdWord[CFG_OSC_HALVE_BIT] = q.oscHalve;
        rdWord[CFG_MCU_SEL_LSB +: 2] = q.mcuSel;
      end
      ADDR_THRESH: begin
        rdWord[THR_TGT_LSB +: 4] = q.tgtThr;
        rdWord[THR_CA_LSB +: 4] = q.caThr;
      end
      ADDR_REG_DEF: begin
        rdWord[REG_CODE_LSB +: 4] = q.supply_level_code;
        rdWord[REG_MANUAL_BIT] = q.manualSel;
      end
      ADDR_REG_DISP: rdWord[3:0] = dispValue; // RULE14
      ADDR_STATUS: begin
        rdWord[ST_FIELD_BIT] = tgtLive; // RULE5
        rdWord[ST_OSC_OK_BIT] = q.oscS2;
        rdWord[ST_CA_BUSY_BIT] = caActive;
        rdWord[ST_ADJ_BUSY_BIT] = (q.seq == SEQ_ADJ);
      end
      ADDR_IRQ: rdWord[IRQ_W-1:0] = q.irq;
      default: rdWord = ZERO_WORD;
    endcase
  end

  // Next state
  always_comb begin
    d = q;
    d.txStart = 1'b0;

    // Two-flop synchronisers and edge history
    d.tgtS1 = tgtCmpIn; // RULE21
    d.tgtS2 = q.tgtS1;
    d.caS1 = caCmpIn;
    d.caS2 = q.caS1;
    d.oscS1 = oscAmpOkIn;
    d.oscS2 = q.oscS1;
    d.comboPrev = comboDet;
    d.tgtPrev = tgtLive;
    d.oscPrev = q.oscS2;

    // Core tick: every cycle, or every other for a doubled crystal
    d.halfPhase = q.oscHalve ? ~q.halfPhase : 1'b0; // RULE10
    d.coreTick = ~q.oscHalve | q.halfPhase; // RULE10

    // Host clock divider on core ticks
    if (q.coreTick) begin
      if (q.mcuCnt >= halfTicks) begin
        d.mcuCnt = 2'd0;
        d.mcuClk = ~q.mcuClk; // RULE11
      end else begin
        d.mcuCnt = q.mcuCnt + 2'd1;
      end
    end

    // Register bus: setup captures answer, access commits write
    if (setupPhase) begin
      d.prdata = apbReq.pwrite ? ZERO_WORD : rdWord;
      d.pslverr = ~isMapped(apbReq.paddr);
    end
    if (wrStrobe) begin
      case (apbReq.paddr)
        ADDR_OP_CTRL: begin
          d.readyEn = apbReq.pwdata[OP_READY_BIT];
          d.nfcTgt = apbReq.pwdata[OP_NFC_TGT_BIT];
        end
        ADDR_CONFIG2: begin
          d.oscHalve = apbReq.pwdata[CFG_OSC_HALVE_BIT];
          d.mcuSel = apbReq.pwdata[CFG_MCU_SEL_LSB +: 2];
        end
        ADDR_THRESH: begin
          d.tgtThr = apbReq.pwdata[THR_TGT_LSB +: 4]; // RULE2
          d.caThr = apbReq.pwdata[THR_CA_LSB +: 4]; // RULE2
        end
        ADDR_REG_DEF: begin
          d.supply_level_code = apbReq.pwdata[REG_CODE_LSB +: 4];
          d.manualSel = apbReq.pwdata[REG_MANUAL_BIT]; // RULE18
        end
        default: d.readyEn = q.readyEn;
      endcase
    end

    // Sequencer for collision avoidance and regulator adjust
    case (q.seq)
      SEQ_IDLE: begin
        // Commands only taken while idle
        d.seqCnt = '0;
        d.collide = 1'b0;
        if (wrStrobe && apbReq.paddr == ADDR_COMMAND) begin
          if (apbReq.pwdata[7:0] == CMD_START_CA) begin
            d.seq = SEQ_CA; // RULE6
          end else if (apbReq.pwdata[7:0] == CMD_ADJUST_REG) begin
            d.seq = SEQ_ADJ; // RULE17
          end
        end
      end
      SEQ_CA: begin
        // Any field seen in the window blocks the send
        if (caLive) begin
          d.collide = 1'b1; // RULE7
        end
        if (q.seqCnt == SEQ_CNT_W'(CA_WINDOW_CYCLES - 1)) begin
          d.seq = SEQ_IDLE;
          d.txStart = ~(q.collide | caLive); // RULE6 RULE7
        end else begin
          d.seqCnt = q.seqCnt + 1'b1;
        end
      end
      SEQ_ADJ: begin
        // Supply sampled once the settle time is over
        if (q.seqCnt == SEQ_CNT_W'(ADJ_SETTLE_CYCLES - 1)) begin
          d.seq = SEQ_IDLE;
          d.autoLevel = autoTarget(vddLevelIn); // RULE17 RULE12
        end else begin
          d.seqCnt = q.seqCnt + 1'b1;
        end
      end
      default: d.seq = SEQ_IDLE;
    endcase

    // Sticky sources: read clears, a new event in the same cycle wins
    d.irq = (rdIrqStrobe ? '0 : q.irq) | irqSet; // RULE19
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.seq <= SEQ_IDLE;
      q.autoLevel <= LEVEL_RESET; // RULE16
    end else begin
      q <= d;
    end
  end

  // Bus answer, no wait states
  assign apbRsp.prdata = q.prdata;
  assign apbRsp.pready = accessPhase;
  assign apbRsp.pslverr = accessPhase & q.pslverr;

  // Detector controls
  assign tgtEnableOut = q.nfcTgt & ~caActive; // RULE3 RULE8
  assign caEnableOut = caActive; // RULE6
  assign tgtThresholdOut = q.tgtThr;
  assign caThresholdOut = q.caThr;

  // Send permission and clocks
  assign txStartOut = q.txStart;
  assign coreTickOut = q.coreTick;
  assign mcuClkOut = q.mcuClk;

  // Regulators and interrupt pin
  assign regEnableOut = regOn; // RULE13
  assign supplyLevelOut = levelNow; // RULE12
  assign irq_line_out = |q.irq; // RULE19

endmodule // frc_field_osc_regulator

`default_nettype wire

// [design/frc_pkg.sv]
// Package for the field detector, oscillator and regulator control block
package frc_pkg;

  // Clock and timing
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int CA_WINDOW_NS = 20000;
  localparam int CA_WINDOW_CYCLES = CA_WINDOW_NS / CLOCK_PERIOD_NS;
  localparam int ADJ_SETTLE_NS = 1000;
  localparam int ADJ_SETTLE_CYCLES =
    (ADJ_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SEQ_CNT_W = 10;

  // Register byte offsets
  localparam logic [7:0] ADDR_OP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG2 = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_REG_DEF = 8'h0C;
  localparam logic [7:0] ADDR_REG_DISP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ = 8'h18;
  localparam logic [7:0] ADDR_COMMAND = 8'h1C;

  // Operation control fields
  localparam int OP_READY_BIT = 0;
  localparam int OP_NFC_TGT_BIT = 1;
  // Configuration 2 fields
  localparam int CFG_OSC_HALVE_BIT = 0;
  localparam int CFG_MCU_SEL_LSB = 1;
  // Threshold fields
  localparam int THR_TGT_LSB = 0;
  localparam int THR_CA_LSB = 4;
  // Regulator definition fields
  localparam int REG_CODE_LSB = 0;
  localparam int REG_MANUAL_BIT = 4;
  // Status fields
  localparam int ST_FIELD_BIT = 0;
  localparam int ST_OSC_OK_BIT = 1;
  localparam int ST_CA_BUSY_BIT = 2;
  localparam int ST_ADJ_BUSY_BIT = 3;
  // Interrupt source bits
  localparam int IRQ_NFC_BIT = 0;
  localparam int IRQ_COLL_BIT = 1;
  localparam int IRQ_OSC_BIT = 2;
  localparam int IRQ_W = 3;

  // Direct command codes
  localparam logic [7:0] CMD_ADJUST_REG = 8'h01;
  localparam logic [7:0] CMD_START_CA = 8'h02;

  // Supply level codes: 0 is 2.4 V, each step 100 mV
  localparam logic [3:0] LEVEL_MAX = 4'hA;
  localparam logic [3:0] LEVEL_RESET = 4'hA;
  localparam logic [3:0] DISP_OFF = 4'h0;
  // Vdd in 50 mV units above 2.4 V; 250 mV margin is 5 units
  localparam logic [5:0] VDD_MARGIN = 6'h05;

  // Host clock selections (half period in core ticks, less one)
  localparam logic [1:0] MCU_FULL = 2'h0;
  localparam logic [1:0] MCU_HALF = 2'h1;

  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CA,
    SEQ_ADJ
  } frc_seq_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } frc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } frc_apb_rsp_type;

endpackage

// [tb/frc_rf_field.sv]
// Model of the external RF field seen by the two detectors
`timescale 1ns/100ps
`default_nettype none
module frc_rf_field (
  input wire logic tgtEn,
  input wire logic caEn,
  input wire logic [3:0] tgtThr,
  input wire logic [3:0] caThr,
  output var logic tgtCmp,
  output var logic caCmp,
  output var logic oscOk
);
  logic [4:0] amp = 5'h00; // Field strength, set by the bench
  logic oscOn = 1'b0;
  // Unpowered comparators sit low
  always_comb begin
    tgtCmp = tgtEn && (amp > {1'b0, tgtThr});
    caCmp = caEn && (amp > {1'b0, caThr});
    oscOk = oscOn;
  end
endmodule // frc_rf_field
`default_nettype wire

// [tb/frc_checker.sv]
// Port checker for the field, oscillator and regulator block
`timescale 1ns/100ps
`default_nettype none
module frc_checker
  import frc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tgtCmpIn,
  input wire logic caCmpIn,
  input wire logic readyModeIn,
  input wire logic tgtEnableOut,
  input wire logic caEnableOut,
  input wire logic txStartOut,
  input wire logic coreTickOut,
  input wire logic mcuClkOut,
  input wire logic regEnableOut,
  input wire logic [3:0] supplyLevelOut,
  input wire logic irq_line_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Relations at the ports
  property p_rdy; readyModeIn |-> regEnableOut; endproperty
  a_rdy: assert property (p_rdy)
    else $error("regulators off");
  property p_excl; caEnableOut |-> !tgtEnableOut; endproperty
  a_excl: assert property (p_excl)
    else $error("target on in CA");
  property p_tx1; txStartOut |=> !txStartOut; endproperty
  a_tx1: assert property (p_tx1)
    else $error("long tx pulse");
  property p_txca;
    txStartOut |-> !caEnableOut && ($past(caEnableOut) ||
      $past(caEnableOut, 2));
  endproperty
  a_txca: assert property (p_txca)
    else $error("tx without CA");
  property p_max; supplyLevelOut <= LEVEL_MAX; endproperty
  a_max: assert property (p_max)
    else $error("level too high");
  property p_pup; $past(sys_rst) |-> supplyLevelOut == LEVEL_RESET;
  endproperty
  a_pup: assert property (p_pup)
    else $error("bad power-up level");
  property p_tick; !coreTickOut |=> coreTickOut; endproperty
  a_tick: assert property (p_tick)
    else $error("tick missing");
  property p_mcu;
    $changed(mcuClkOut) |-> ##[1:8] $changed(mcuClkOut);
  endproperty
  a_mcu: assert property (p_mcu)
    else $error("host clock stuck");
  property p_nfc;
    $rose(tgtCmpIn) && tgtEnableOut |-> ##[1:4] irq_line_out;
  endproperty
  a_nfc: assert property (p_nfc)
    else $error("no field irq");
  property p_col;
    $rose(caCmpIn) && caEnableOut |-> ##[1:4] irq_line_out;
  endproperty
  a_col: assert property (p_col)
    else $error("no collision irq");
endmodule // frc_checker
bind frc_field_osc_regulator frc_checker u_chk (.clock(clock),
  .sys_rst(sys_rst), .tgtCmpIn(tgtCmpIn), .caCmpIn(caCmpIn),
  .readyModeIn(readyModeIn), .tgtEnableOut(tgtEnableOut),
  .caEnableOut(caEnableOut), .txStartOut(txStartOut),
  .coreTickOut(coreTickOut), .mcuClkOut(mcuClkOut),
  .regEnableOut(regEnableOut), .supplyLevelOut(supplyLevelOut),
  .irq_line_out(irq_line_out));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the field, oscillator and regulator block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import frc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  frc_apb_req_type apbReq = '0;
  frc_apb_rsp_type apbRsp;
  logic readyModeIn = 1'b0;
  logic [5:0] vddLevelIn = 6'h3F;
  logic tgtCmpIn, caCmpIn, oscAmpOkIn, tgtEn, caEn, txStart, tick, mcuClk;
  logic regEn, irq_line_out, er, prev;
  logic [3:0] tgtThr, caThr, level;
  logic [31:0] rd, v;
  int seed = 60012;
  int n_mismatch = 0;
  int total_checks = 0;
  int w, tk, tg;
  always #20 clock = ~clock;
  frc_field_osc_regulator uut (.clock(clock), .sys_rst(sys_rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .tgtCmpIn(tgtCmpIn),
    .caCmpIn(caCmpIn), .oscAmpOkIn(oscAmpOkIn), .readyModeIn(readyModeIn),
    .vddLevelIn(vddLevelIn), .tgtEnableOut(tgtEn), .caEnableOut(caEn),
    .tgtThresholdOut(tgtThr), .caThresholdOut(caThr), .txStartOut(txStart),
    .coreTickOut(tick), .mcuClkOut(mcuClk), .regEnableOut(regEn),
    .supplyLevelOut(level), .irq_line_out(irq_line_out));
  frc_rf_field pf (.tgtEn(tgtEn), .caEn(caEn), .tgtThr(tgtThr),
    .caThr(caThr), .tgtCmp(tgtCmpIn), .caCmp(caCmpIn), .oscOk(oscAmpOkIn));
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    apbReq <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (apbRsp.pready !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    #1;
  endtask
  // Automatic level: 250 mV under the logic supply, capped
  function automatic int exp_auto(input int vdd);
    return ((vdd - 5) / 2 > 10) ? 10 : (vdd - 5) / 2;
  endfunction
  // One collision avoidance run, field optionally raised at cycle f
  task automatic run_ca(input int f, input int tx, input logic coll);
    int t, on, both;
    t = 0;
    on = 0;
    both = 0;
    apb(1'b1, ADDR_COMMAND, {24'h00_0000, CMD_START_CA});
    for (int i = 0; i < CA_WINDOW_CYCLES + 40; i++) begin
      @(negedge clock);
      if (i == f) pf.amp = 5'h10;
      t += txStart;
      on += caEn;
      both += caEn & tgtEn;
    end
    pf.amp = 5'h00;
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk(t, tx);
    chk(on, CA_WINDOW_CYCLES);
    chk(both, 0);
    chk(rd[IRQ_COLL_BIT], coll);
  endtask
  // Counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk(level, LEVEL_RESET);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, ADDR_THRESH, {24'h00_0000, v[7:0]});
      chk({caThr, tgtThr}, v[7:0]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, ADDR_REG_DISP, 32'h0);
    chk(regEn, 1'b0);
    chk(rd, 32'h0000_0000);
    readyModeIn <= 1'b1;
    apb(1'b0, ADDR_REG_DISP, 32'h0);
    chk(regEn, 1'b1);
    chk(rd, 32'(LEVEL_RESET));
    readyModeIn <= 1'b0;
    apb(1'b1, ADDR_OP_CTRL, 32'h1);
    chk(regEn, 1'b1);
    $display("test regulators done");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, ADDR_REG_DEF, 32'h10 | c);
      chk(level, (c > 10) ? 10 : c);
    end
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      w = (k == 0) ? 5 : (k == 1) ? 63 : 5 + (v & 31);
      vddLevelIn <= 6'(w);
      apb(1'b1, ADDR_REG_DEF, 32'h0);
      apb(1'b1, ADDR_COMMAND, {24'h00_0000, CMD_ADJUST_REG});
      repeat (ADJ_SETTLE_CYCLES + 5) @(posedge clock);
      #1;
      chk(level, exp_auto(w));
    end
    $display("test levels done");
    apb(1'b0, ADDR_IRQ, 32'h0);
    pf.oscOn = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk(irq_line_out, 1'b1);
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, ADDR_OP_CTRL, 32'h3);
    chk(tgtEn, 1'b1);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) apb(1'b1, ADDR_OP_CTRL, 32'h1);
      pf.amp = (k == 1) ? 5'h00 : 5'h10;
      repeat (5) @(posedge clock);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, (k == 0) ? 32'h3 : 32'h2);
      apb(1'b0, ADDR_IRQ, 32'h0);
      chk(rd, (k == 2) ? 32'h0 : 32'h1);
    end
    pf.amp = 5'h00;
    apb(1'b1, ADDR_OP_CTRL, 32'h3);
    run_ca(-1, 1, 1'b0);
    run_ca(60, 0, 1'b1);
    $display("test field done");
    for (int h = 0; h < 2; h++)
      for (int s = 0; s < 4; s++) begin
        apb(1'b1, ADDR_CONFIG2, 32'(h | (s << 1)));
        tk = 0;
        tg = 0;
        repeat (10) @(negedge clock);
        prev = mcuClk;
        for (int i = 0; i < 64; i++) begin
          @(negedge clock);
          tk += tick;
          tg += (mcuClk !== prev);
          prev = mcuClk;
        end
        chk(tk, 64 >> h);
        chk(tg, 64 >> (h + ((s > 2) ? 2 : s)));
      end
    $display("test clocks done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
